// file: rtl/event_irq.sv
// sticky event status, mask and level interrupt output
// assumes write strobes are one-cycle pulses from the register slave
module event_irq
  import hostport_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // event pulses
  input wire logic [EVT_W-1:0] i_evt,
  // software access
  input wire logic i_status_wr,
  input wire logic i_mask_wr,
  input wire logic [EVT_W-1:0] i_wdata,
  // state and interrupt
  output logic [EVT_W-1:0] o_status,
  output logic [EVT_W-1:0] o_mask,
  output logic o_irq
);

  logic [EVT_W-1:0] status_q, status_d;
  logic [EVT_W-1:0] mask_q, mask_d;

  // ==========================================================
  // next state: write one clears, a new event wins over the clear
  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (i_status_wr) begin
      status_d = status_q & ~i_wdata;
    end
    status_d = status_d | i_evt;
    if (i_mask_wr) begin
      mask_d = i_wdata;
    end
  end

  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  assign o_status = status_q;
  assign o_mask = mask_q;
  // level output while any unmasked bit stands
  assign o_irq = |(status_q & mask_q);

endmodule

// file: rtl/host_port.sv
// port d/e registers with an 8-bit parallel slave port for a host cpu
// assumes an apb master on I_CORE_CLK and asynchronous host strobes on pins
//
// Behaviour
// - host enable (bit 4 of port e direction) makes port d a host port.
// - the host reads and writes with no clock, using only its strobes.
// - the host sees the port d latch as one 8-bit read-write latch.
// - host mode: port e bit 0 is read, bit 1 write, bit 2 select strobe.
// - host write: select and write strobe first seen low capture port d.
// - host read: select and read strobe first seen low drive the latch.
// - the read strobe is active low and counts only while select is low.
// - the write strobe is active low and counts only while select is low.
// - select is active low; while high both strobes are ignored.
module host_port
  import hostport_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // apb slave
  input wire logic i_PSEL,
  input wire logic i_PENABLE,
  input wire logic i_PWRITE,
  input wire logic [hostport_pkg::ADDR_W-1:0] i_PADDR,
  input wire logic [hostport_pkg::DATA_W-1:0] i_PWDATA,
  output logic [hostport_pkg::DATA_W-1:0] o_PRDATA,
  output logic o_PREADY,
  output logic o_PSLVERR,
  // port d pins
  input wire logic [hostport_pkg::PD_W-1:0] i_PORT_D_IN,
  output logic [hostport_pkg::PD_W-1:0] o_PORT_D_OUT,
  output logic [hostport_pkg::PD_W-1:0] o_PORT_D_OE,
  // port e pins
  input wire logic [hostport_pkg::PE_W-1:0] i_PORT_E_IN,
  output logic [hostport_pkg::PE_W-1:0] o_PORT_E_OUT,
  output logic [hostport_pkg::PE_W-1:0] o_PORT_E_OE,
  // interrupt
  output logic o_IRQ
);

  // ==========================================================
  // address decode, used by the read path and the write path
  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_PORT_D_PIN: decode = SEL_PORT_D_PIN;
      OFS_PORT_D_LAT: decode = SEL_PORT_D_LAT;
      OFS_PORT_D_DIR: decode = SEL_PORT_D_DIR;
      OFS_PORT_E_PIN: decode = SEL_PORT_E_PIN;
      OFS_PORT_E_LAT: decode = SEL_PORT_E_LAT;
      OFS_PORT_E_DIR: decode = SEL_PORT_E_DIR;
      OFS_GLOBAL_IRQ: decode = SEL_GLOBAL_IRQ;
      OFS_PIR_ONE: decode = SEL_PIR_ONE;
      OFS_PIE_ONE: decode = SEL_PIE_ONE;
      OFS_IPR_ONE: decode = SEL_IPR_ONE;
      OFS_ANALOG_CFG: decode = SEL_ANALOG_CFG;
      OFS_EVT_STATUS: decode = SEL_EVT_STATUS;
      OFS_EVT_MASK: decode = SEL_EVT_MASK;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  host_pins_type pins_raw, pins;

  assign pins_raw = '{data: i_PORT_D_IN, ctl: i_PORT_E_IN};

  // strobes arrive with no relation to the core clock
  pin_sync #(
    .W(PD_W + PE_W)
  ) u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // ==========================================================
  // register state
  logic [7:0] dlat_q, dlat_d;
  logic [7:0] ddir_q, ddir_d;
  logic [2:0] late_q, late_d;
  logic [3:0] edir_q, edir_d; // host enable and direction bits
  host_flags_type flags_q, flags_d;
  logic [7:0] gctl_q, gctl_d;
  logic [7:0] pir_q, pir_d;
  logic [7:0] pie_q, pie_d;
  logic [7:0] ipr_q, ipr_d;
  logic [7:0] adcon_q, adcon_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic err_q, err_d;

  // ==========================================================
  // host port sequencer
  typedef enum logic [1:0] {HOST_IDLE, HOST_WRITE, HOST_READ} host_state_type;
  host_state_type state_q, state_d;

  logic host_en;
  logic sel_act;
  logic wr_act;
  logic rd_act;
  logic host_wr_evt;
  logic host_rd_evt;
  logic host_done;

  assign host_en = edir_q[HOST_EN_SLOT];
  // strobes only count while selected
  assign sel_act = host_en & ~pins.ctl[PE_CS];
  assign wr_act = sel_act & ~pins.ctl[PE_WR];
  assign rd_act = sel_act & ~pins.ctl[PE_RD];

  // first detection opens an access, its end closes it
  always_comb begin
    state_d = state_q;
    host_wr_evt = 1'b0;
    host_rd_evt = 1'b0;
    host_done = 1'b0;
    case (state_q)
      HOST_IDLE: begin
        if (wr_act) begin
          state_d = HOST_WRITE;
          host_wr_evt = 1'b1;
        end else if (rd_act) begin
          state_d = HOST_READ;
          host_rd_evt = 1'b1;
        end
      end
      HOST_WRITE: begin
        if (!wr_act) begin
          state_d = HOST_IDLE;
          host_done = 1'b1;
        end
      end
      HOST_READ: begin
        if (!rd_act) begin
          state_d = HOST_IDLE;
          host_done = 1'b1;
        end
      end
      default: begin
        state_d = HOST_IDLE;
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= HOST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // apb decode
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_acc;
  reg_sel_type acc_sel;
  reg_sel_type setup_sel;
  logic [7:0] wbyte;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;

  assign setup = i_PSEL & ~i_PENABLE;
  assign access = i_PSEL & i_PENABLE;
  assign acc_sel = decode(i_PADDR);
  assign setup_sel = acc_sel;
  assign wr_acc = access & i_PWRITE;
  assign rd_acc = access & ~i_PWRITE;
  assign wbyte = i_PWDATA[7:0];

  // ==========================================================
  // register next values, hardware sets win over software clears
  always_comb begin
    dlat_d = dlat_q;
    ddir_d = ddir_q;
    late_d = late_q;
    edir_d = edir_q;
    flags_d = flags_q;
    gctl_d = gctl_q;
    pir_d = pir_q;
    pie_d = pie_q;
    ipr_d = ipr_q;
    adcon_d = adcon_q;
    if (wr_acc) begin
      case (acc_sel)
        SEL_PORT_D_PIN, SEL_PORT_D_LAT: begin
          dlat_d = wbyte;
          if (host_en) begin
            flags_d.out_full = 1'b1;
          end
        end
        SEL_PORT_D_DIR: ddir_d = wbyte;
        SEL_PORT_E_LAT: late_d = wbyte[2:0];
        SEL_PORT_E_DIR: begin
          // bit 3 of the word is unimplemented, the enable sits in slot 3
          edir_d[HOST_EN_SLOT] = wbyte[HSTAT_EN];
          edir_d[2:0] = wbyte[2:0];
          if (!wbyte[HSTAT_OVFL]) begin
            flags_d.in_ovfl = 1'b0;
          end
        end
        SEL_GLOBAL_IRQ: gctl_d = wbyte;
        SEL_PIR_ONE: pir_d = wbyte;
        SEL_PIE_ONE: pie_d = wbyte;
        SEL_IPR_ONE: ipr_d = wbyte;
        SEL_ANALOG_CFG: adcon_d = wbyte & ANALOG_CFG_MASK;
        default: begin
        end
      endcase
    end
    // software read of the port data drains the input latch
    if (rd_acc && acc_sel == SEL_PORT_D_PIN && host_en) begin
      flags_d.in_full = 1'b0;
    end
    // host write captures the bus into the single latch
    if (host_wr_evt) begin
      dlat_d = pins.data;
      flags_d.in_full = 1'b1;
      if (flags_q.in_full) begin
        flags_d.in_ovfl = 1'b1;
      end
    end
    if (host_rd_evt) begin
      flags_d.out_full = 1'b0;
    end
    if (host_done) begin
      pir_d[PIR_HOST_IRQ] = 1'b1;
    end
  end

  // ==========================================================
  // read data and error, captured in the setup cycle
  always_comb begin
    prdata_d = '0;
    err_d = 1'b0;
    if (setup && !i_PWRITE) begin
      case (setup_sel)
        SEL_PORT_D_PIN: prdata_d[7:0] = host_en ? dlat_q : pins.data;
        SEL_PORT_D_LAT: prdata_d[7:0] = dlat_q;
        SEL_PORT_D_DIR: prdata_d[7:0] = ddir_q;
        SEL_PORT_E_PIN: prdata_d[2:0] = pins.ctl;
        SEL_PORT_E_LAT: prdata_d[2:0] = late_q;
        SEL_PORT_E_DIR: prdata_d[7:0] = {flags_q.in_full, flags_q.out_full,
          flags_q.in_ovfl, edir_q[HOST_EN_SLOT], 1'b0, edir_q[2:0]};
        SEL_GLOBAL_IRQ: prdata_d[7:0] = gctl_q;
        SEL_PIR_ONE: prdata_d[7:0] = pir_q;
        SEL_PIE_ONE: prdata_d[7:0] = pie_q;
        SEL_IPR_ONE: prdata_d[7:0] = ipr_q;
        SEL_ANALOG_CFG: prdata_d[7:0] = adcon_q;
        SEL_EVT_STATUS: prdata_d[EVT_W-1:0] = evt_status;
        SEL_EVT_MASK: prdata_d[EVT_W-1:0] = evt_mask;
        default: err_d = 1'b1;
      endcase
    end else if (setup) begin
      err_d = (setup_sel == SEL_NONE) || (setup_sel == SEL_PORT_E_PIN);
    end
  end

  // register file and answer registers
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      dlat_q <= RST_PORT_D_LAT;
      ddir_q <= RST_PORT_D_DIR;
      late_q <= RST_PORT_E_LAT;
      edir_q <= {1'b0, RST_PORT_E_DIR};
      flags_q <= '0;
      gctl_q <= RST_BYTE;
      pir_q <= RST_BYTE;
      pie_q <= RST_BYTE;
      ipr_q <= RST_BYTE;
      adcon_q <= RST_BYTE;
      prdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      dlat_q <= dlat_d;
      ddir_q <= ddir_d;
      late_q <= late_d;
      edir_q <= edir_d;
      flags_q <= flags_d;
      gctl_q <= gctl_d;
      pir_q <= pir_d;
      pie_q <= pie_d;
      ipr_q <= ipr_d;
      adcon_q <= adcon_d;
      if (setup) begin
        prdata_q <= prdata_d;
        err_q <= err_d;
      end
    end
  end

  // ==========================================================
  // event interrupts
  assign evt[EVT_HOST_WR] = host_wr_evt;
  assign evt[EVT_HOST_RD] = host_rd_evt;
  assign evt[EVT_OVERFLOW] = host_wr_evt & flags_q.in_full;

  event_irq u_event_irq (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_evt(evt),
    .i_status_wr(wr_acc && acc_sel == SEL_EVT_STATUS),
    .i_mask_wr(wr_acc && acc_sel == SEL_EVT_MASK),
    .i_wdata(wbyte[EVT_W-1:0]),
    .o_status(evt_status),
    .o_mask(evt_mask),
    .o_irq(o_IRQ)
  );

  // ==========================================================
  // outputs
  assign o_PRDATA = prdata_q;
  assign o_PREADY = 1'b1; // every access completes in one access cycle
  assign o_PSLVERR = access & err_q;
  assign o_PORT_D_OUT = dlat_q;
  // host mode drives port d only during a host read
  assign o_PORT_D_OE = host_en ? {PD_W{state_q == HOST_READ}}
                               : ~ddir_q;
  assign o_PORT_E_OUT = late_q;
  // direction bits are trusted to be inputs in host mode
  assign o_PORT_E_OE = ~edir_q[2:0];

endmodule

// file: rtl/pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
// assumes every bit is an independent level from outside the clock domain
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pins and synchronised levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // ==========================================================
  // one two-flop chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first stage feeds only the second
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule

// file: shared/hostport_pkg.sv
// holds register offsets, field positions, reset values and types shared
// by the host port block and its helpers
// assumes a 32-bit apb register bus with byte addresses
package hostport_pkg;

  // ==========================================================
  // bus, pin and event widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PD_W = 8;
  localparam int PE_W = 3;
  localparam int EVT_W = 3;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PORT_D_PIN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_D_LAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_D_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_PIN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_LAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_IRQ = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PIR_ONE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PIE_ONE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IPR_ONE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h30;

  // ==========================================================
  // register selector codes
  typedef enum logic [3:0] {
    SEL_PORT_D_PIN, SEL_PORT_D_LAT, SEL_PORT_D_DIR, SEL_PORT_E_PIN,
    SEL_PORT_E_LAT, SEL_PORT_E_DIR, SEL_GLOBAL_IRQ, SEL_PIR_ONE,
    SEL_PIE_ONE, SEL_IPR_ONE, SEL_ANALOG_CFG, SEL_EVT_STATUS,
    SEL_EVT_MASK, SEL_NONE
  } reg_sel_type;

  // ==========================================================
  // field positions
  localparam int HSTAT_IN_FULL = 7;
  localparam int HSTAT_OUT_FULL = 6;
  localparam int HSTAT_OVFL = 5;
  localparam int HSTAT_EN = 4;
  // slot of the enable bit inside the stored 4-bit direction word
  localparam int HOST_EN_SLOT = 3;
  localparam int PIR_HOST_IRQ = 7;
  localparam int PE_RD = 0;
  localparam int PE_WR = 1;
  localparam int PE_CS = 2;
  localparam int EVT_HOST_WR = 0;
  localparam int EVT_HOST_RD = 1;
  localparam int EVT_OVERFLOW = 2;
  localparam logic [7:0] ANALOG_CFG_MASK = 8'hcf;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PORT_D_LAT = 8'h00;
  localparam logic [7:0] RST_PORT_D_DIR = 8'hff;
  localparam logic [2:0] RST_PORT_E_LAT = 3'h0;
  localparam logic [2:0] RST_PORT_E_DIR = 3'h7;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==========================================================
  // grouped signals
  typedef struct packed {
    logic in_full;
    logic out_full;
    logic in_ovfl;
  } host_flags_type;

  typedef struct packed {
    logic [PD_W-1:0] data;
    logic [PE_W-1:0] ctl;
  } host_pins_type;

endpackage

// file: testbench/host_cpu_model.sv
// external processor model driving the host port pins
// assumes xfer is called just after a rising edge of the paced clock
module host_cpu_model (
  // pacing clock, never handed to the device
  input wire logic i_clk,
  // port d as driven by the device
  input wire logic [7:0] i_pd_out,
  input wire logic [7:0] i_pd_oe,
  // pin levels seen by the device
  output logic [7:0] o_pd_in,
  output logic [2:0] o_pe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_en = 1'b0;
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;

  // strobes idle high, no clock of ours reaches the device
  initial o_pe_in = 3'h7;
  always @(posedge i_clk) last <= o_pd_in;
  // undriven bits flip each cycle so a stale byte cannot pass
  assign o_pd_in = (i_pd_oe & i_pd_out) | (~i_pd_oe & (drv_en ? drv : ~last));

  // one strobed access; data set up 4 edges before and held 4 after
  task automatic xfer(input logic wr, input logic sel_n,
                      input logic [7:0] wd, output logic [7:0] rd);
    drv_en <= wr;
    drv <= wd;
    repeat (4) @(posedge i_clk);
    o_pe_in <= {sel_n, ~wr, wr};
    repeat (6) @(posedge i_clk);
    rd = o_pd_in;
    o_pe_in <= 3'h7;
    repeat (4) @(posedge i_clk);
    drv_en <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// file: testbench/host_port_monitor.sv
// checker for the host port: bus answers, host strobes and interrupt
// assumes it is bound onto host_port and sees only its ports
module host_port_monitor
  import hostport_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // apb
  input wire logic i_PSEL,
  input wire logic i_PENABLE,
  input wire logic i_PWRITE,
  input wire logic [hostport_pkg::ADDR_W-1:0] i_PADDR,
  input wire logic [hostport_pkg::DATA_W-1:0] i_PWDATA,
  input wire logic [hostport_pkg::DATA_W-1:0] o_PRDATA,
  input wire logic o_PREADY,
  input wire logic o_PSLVERR,
  // pins and interrupt
  input wire logic [hostport_pkg::PD_W-1:0] i_PORT_D_IN,
  input wire logic [hostport_pkg::PD_W-1:0] o_PORT_D_OUT,
  input wire logic [hostport_pkg::PD_W-1:0] o_PORT_D_OE,
  input wire logic [hostport_pkg::PE_W-1:0] i_PORT_E_IN,
  input wire logic [hostport_pkg::PE_W-1:0] o_PORT_E_OUT,
  input wire logic [hostport_pkg::PE_W-1:0] o_PORT_E_OE,
  input wire logic o_IRQ
);
  logic wr_acc;
  logic rd_any;
  logic wr_any;
  logic en_q;
  logic en_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  logic [2:0] idle_q;
  logic [2:0] idle_d;

  // ==========================================================
  // shadow state: strobes are active low, held high when idle
  assign wr_acc = i_PSEL & i_PENABLE & i_PWRITE;
  assign rd_any = i_PORT_E_IN[PE_CS] | i_PORT_E_IN[PE_RD];
  assign wr_any = i_PORT_E_IN[PE_CS] | i_PORT_E_IN[PE_WR];

  // next shadow values and saturating quiet and idle counts
  always_comb begin
    en_d = en_q;
    dir_d = dir_q;
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    idle_d = (idle_q == 3'h7) ? idle_q : idle_q + 3'h1;
    if (!(rd_any & wr_any)) begin
      idle_d = 3'h0;
    end
    if (wr_acc) begin
      quiet_d = 3'h0;
      if (i_PADDR == OFS_PORT_E_DIR) begin
        en_d = i_PWDATA[HSTAT_EN];
      end
      if (i_PADDR == OFS_PORT_D_DIR) begin
        dir_d = i_PWDATA[7:0];
      end
    end
  end

  // register the shadow state
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_q <= 1'b0;
      dir_q <= 8'hff;
      quiet_q <= 3'h7;
      idle_q <= 3'h0;
    end else begin
      en_q <= en_d;
      dir_q <= dir_d;
      quiet_q <= quiet_d;
      idle_q <= idle_d;
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  wr_capture_a: assert property (en_q && quiet_q > 3'h2
    && $fell(wr_any) |-> ##[2:4] (o_PORT_D_OUT == i_PORT_D_IN))
    else $error("host write not captured");
  rd_drive_a: assert property (en_q && quiet_q > 3'h2
    && $fell(rd_any) && i_PORT_E_IN[PE_WR] |-> ##[2:4] (o_PORT_D_OE == 8'hff))
    else $error("host read not driven");
  rd_release_a: assert property (en_q && quiet_q > 3'h2
    && $rose(rd_any) |-> ##[2:4] (o_PORT_D_OE == ~dir_q))
    else $error("host read not released");
  oe_idle_a: assert property (quiet_q > 3'h2
    && (!en_q || idle_q > 3'h4) |-> o_PORT_D_OE == ~dir_q)
    else $error("port d driven while idle");
  irq_clear_a: assert property (wr_acc && idle_q > 3'h4
    && i_PADDR == OFS_EVT_STATUS && i_PWDATA[2:0] == 3'h7 |=> !o_IRQ)
    else $error("irq stays after clear");
  irq_mask_a: assert property (wr_acc && i_PADDR == OFS_EVT_MASK
    && i_PWDATA[2:0] == 3'h0 |=> !o_IRQ)
    else $error("irq stays when masked");
  bus_err_a: assert property (i_PSEL && i_PENABLE && !i_PWRITE
    |-> o_PSLVERR == (i_PADDR > OFS_EVT_MASK || i_PADDR[1:0] != 2'h0))
    else $error("bus error wrong");
  rd_width_a: assert property (i_PSEL && i_PENABLE
    |-> o_PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");

  cover property (en_q && $fell(wr_any));
  cover property (en_q && o_PORT_D_OE == 8'hff);
  cover property ($rose(o_IRQ));
endmodule

// file: testbench/host_port_tb_top.sv
// self-checking bench for host_port with an external processor model
// assumes the monitor and model files are compiled before this one
module host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hostport_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] pa = '0;
  logic [DATA_W-1:0] pwd = '0;
  logic [DATA_W-1:0] prd;
  logic prdy, perr, irq, ev;
  logic [PD_W-1:0] pd_in, pd_out, pd_oe;
  logic [PE_W-1:0] pe_in, pe_out, pe_oe;
  logic [7:0] hb;
  logic [31:0] rv;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  host_port i_dut (.I_CORE_CLK(clk), .I_RST(rst), .i_PSEL(psel),
    .i_PENABLE(pen), .i_PWRITE(pwr), .i_PADDR(pa), .i_PWDATA(pwd),
    .o_PRDATA(prd), .o_PREADY(prdy), .o_PSLVERR(perr),
    .i_PORT_D_IN(pd_in), .o_PORT_D_OUT(pd_out), .o_PORT_D_OE(pd_oe),
    .i_PORT_E_IN(pe_in), .o_PORT_E_OUT(pe_out), .o_PORT_E_OE(pe_oe),
    .o_IRQ(irq));
  host_cpu_model i_host (.i_clk(clk), .i_pd_out(pd_out), .i_pd_oe(pd_oe),
    .o_pd_in(pd_in), .o_pe_in(pe_in));

  // ==========================================================
  // compare, bus and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rv = prd;
    ev = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rv, {24'h0, exp});
    chk({31'h0, ev}, {31'h0, (a > OFS_EVT_MASK)});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    chk({31'h0, ev}, 32'h0);
    chk({31'h0, prdy}, 32'h1);
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ofs [0:8] = '{OFS_PORT_D_LAT, OFS_PORT_D_DIR, OFS_PORT_E_DIR,
      OFS_GLOBAL_IRQ, OFS_PIR_ONE, OFS_PIE_ONE, OFS_IPR_ONE, OFS_ANALOG_CFG,
      OFS_EVT_STATUS};
    logic [7:0] exp [0:8] = '{8'h00, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], exp[i]);
    end
    rd(8'h40, 8'h00);
    apb(1'b1, 8'h40, 8'h12);
    chk({31'h0, ev}, 32'h1);
    apb(1'b1, OFS_PORT_E_PIN, 8'h00);
    chk({31'h0, ev}, 32'h1);
    wr(OFS_PORT_E_LAT, 8'h05);
    wr(OFS_PORT_E_DIR, 8'h02);
    @(posedge clk);
    chk({29'h0, pe_out}, 32'h5);
    chk({29'h0, pe_oe}, 32'h5);
    rd(OFS_PORT_E_LAT, 8'h05);
    wr(OFS_PORT_E_DIR, 8'h07);
    @(posedge clk);
    chk({29'h0, pe_oe}, 32'h0);
  endtask
  task automatic t_host_write();
    wr(OFS_ANALOG_CFG, 8'h07);
    wr(OFS_PORT_E_DIR, 8'h17);
    i_host.xfer(1'b1, 1'b0, 8'ha5, hb);
    rd(OFS_PORT_D_LAT, 8'ha5);
    rd(OFS_PORT_E_DIR, 8'h97);
    rd(OFS_EVT_STATUS, 8'h01);
    rd(OFS_PIR_ONE, 8'h80);
    i_host.xfer(1'b1, 1'b0, 8'h5a, hb);
    rd(OFS_PORT_E_DIR, 8'hb7);
    rd(OFS_EVT_STATUS, 8'h05);
    rd(OFS_PORT_D_PIN, 8'h5a);
    rd(OFS_PORT_E_DIR, 8'h37);
    wr(OFS_PORT_E_DIR, 8'h17);
    wr(OFS_EVT_STATUS, 8'h07);
    wr(OFS_PIR_ONE, 8'h00);
  endtask
  task automatic t_host_read();
    wr(OFS_PORT_D_PIN, 8'h3c);
    rd(OFS_PORT_E_DIR, 8'h57);
    i_host.xfer(1'b0, 1'b0, 8'h00, hb);
    chk({24'h0, hb}, 32'h3c);
    rd(OFS_PORT_E_DIR, 8'h17);
    rd(OFS_EVT_STATUS, 8'h02);
    rd(OFS_PIR_ONE, 8'h80);
    wr(OFS_EVT_STATUS, 8'h07);
  endtask
  task automatic t_ignored();
    i_host.xfer(1'b1, 1'b1, 8'hee, hb);
    i_host.xfer(1'b0, 1'b1, 8'h00, hb);
    rd(OFS_EVT_STATUS, 8'h00);
    rd(OFS_PORT_D_LAT, 8'h3c);
    wr(OFS_PORT_E_DIR, 8'h07);
    i_host.xfer(1'b1, 1'b0, 8'h11, hb);
    rd(OFS_PORT_D_LAT, 8'h3c);
    rd(OFS_EVT_STATUS, 8'h00);
    wr(OFS_PORT_E_DIR, 8'h17);
  endtask
  task automatic t_irq();
    wr(OFS_EVT_MASK, 8'h01);
    irq_is(1'b0);
    i_host.xfer(1'b1, 1'b0, 8'h99, hb);
    irq_is(1'b1);
    wr(OFS_EVT_MASK, 8'h00);
    irq_is(1'b0);
    wr(OFS_EVT_MASK, 8'h01);
    irq_is(1'b1);
    wr(OFS_EVT_STATUS, 8'h07);
    irq_is(1'b0);
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_host_write();
    t_host_read();
    t_ignored();
    t_irq();
    wrap_up();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
endmodule

bind host_port host_port_monitor i_mon (.I_CORE_CLK(I_CORE_CLK),
  .I_RST(I_RST), .i_PSEL(i_PSEL), .i_PENABLE(i_PENABLE),
  .i_PWRITE(i_PWRITE), .i_PADDR(i_PADDR), .i_PWDATA(i_PWDATA),
  .o_PRDATA(o_PRDATA), .o_PREADY(o_PREADY), .o_PSLVERR(o_PSLVERR),
  .i_PORT_D_IN(i_PORT_D_IN), .o_PORT_D_OUT(o_PORT_D_OUT),
  .o_PORT_D_OE(o_PORT_D_OE), .i_PORT_E_IN(i_PORT_E_IN),
  .o_PORT_E_OUT(o_PORT_E_OUT), .o_PORT_E_OE(o_PORT_E_OE), .o_IRQ(o_IRQ));
